// ### rtl/adc_seq_pkg.sv
// Constants, types and helpers shared by the conversion sequencer files
// How it works
// - Four converter clocks sample the input, twelve more perform the conversion.
// - A conversion lasts exactly sixteen converter clock periods from start to result.
// - Conversion runs in hardware; the bus is never stalled by it.
// - Converter clock is system clock divided by 1 to 128 per divider code.
// - Power enable must be high to convert; low keeps converter unpowered.
// - Source 001 amplifier, 010..100 ground, others external; channels 0..3 pins.
// - Start bit low-high-low: high resets converter, falling edge starts conversion.
// - Busy flag stays high for the whole conversion in progress.
// - On completion busy falls and result bytes hold the new valid result.
// - Result is 12-bit unsigned; full scale FFF equals the supply reference.
// - One code step weighs the reference divided by 4096.
// - Code transitions sit half a step low; the last one and a half.
package adc_seq_pkg;

  // ****************************************
  // Timing and widths
  // ****************************************
  localparam int unsigned SAMPLE_TICKS = 4;
  localparam int unsigned CONVERT_TICKS = 12;
  localparam int unsigned TOTAL_TICKS = SAMPLE_TICKS + CONVERT_TICKS;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned THR_W = RESULT_W + 1;
  localparam int unsigned DIV_SEL_W = 3;
  localparam int unsigned DIV_CNT_W = 7;
  localparam int unsigned PIN_COUNT = 4;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_ZERO_OFF = 8'h00;
  localparam logic [7:0] CTRL_ONE_OFF = 8'h04;
  localparam logic [7:0] PIN_ENABLE_OFF = 8'h08;
  localparam logic [7:0] IRQ_CTRL_OFF = 8'h0c;
  localparam logic [7:0] RESULT_HIGH_OFF = 8'h10;
  localparam logic [7:0] RESULT_LOW_OFF = 8'h14;

  // converter_control_zero fields
  localparam int unsigned CHAN_LSB = 0;
  localparam int unsigned FORMAT_BIT = 4;
  localparam int unsigned POWER_BIT = 5;
  localparam int unsigned BUSY_BIT = 6;
  localparam int unsigned START_BIT = 7;
  // converter_control_one fields
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned SOURCE_LSB = 5;
  // interrupt control fields
  localparam int unsigned GIE_BIT = 0;
  localparam int unsigned CIE_BIT = 1;
  localparam int unsigned FLAG_BIT = 2;

  // Input source codes
  localparam logic [2:0] SRC_AMP = 3'h1;
  localparam logic [2:0] SRC_GND_LO = 3'h2;
  localparam logic [2:0] SRC_GND_HI = 3'h4;
  localparam logic [3:0] LAST_PIN_CHAN = 4'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SAMPLE, ST_CONVERT} seq_state_t;
  typedef enum logic [1:0] {ROUTE_PIN, ROUTE_FLOAT, ROUTE_AMP, ROUTE_GND} route_t;

  typedef struct packed {
    logic [2:0] source_sel;
    logic [2:0] div_sel;
    logic power;
    logic fmt;
    logic start;
    logic [3:0] chan;
    logic [3:0] pin_en;
    logic gie;
    logic cie;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic route_t route_of(input logic [2:0] src, input logic [3:0] chan);
    if (src == SRC_AMP) begin
      return ROUTE_AMP;
    end else if (src >= SRC_GND_LO && src <= SRC_GND_HI) begin
      return ROUTE_GND;
    end else if (chan <= LAST_PIN_CHAN) begin
      return ROUTE_PIN;
    end
    return ROUTE_FLOAT;
  endfunction

  // Threshold in half-step units: every transition half a step early
  function automatic logic [THR_W-1:0] threshold_of(input logic [RESULT_W-1:0] code);
    if (code == '0) begin
      return '0;
    end
    return {code, 1'b0} - 13'h0001;
  endfunction

endpackage

// ### rtl/converter_clock_divider.sv
// Power-of-two divider producing one converter clock tick per period
`timescale 1ns/1ps
module converter_clock_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [adc_seq_pkg::DIV_SEL_W-1:0] div_sel,
  output logic tick
);

  logic [adc_seq_pkg::DIV_CNT_W-1:0] cnt_reg;
  logic [adc_seq_pkg::DIV_CNT_W-1:0] cnt_next;
  logic [adc_seq_pkg::DIV_CNT_W-1:0] limit;
  logic tick_reg;
  logic tick_next;
  logic [7:0] span;

  always_comb begin
    span = 8'h01 << div_sel;
    limit = 7'(span - 8'h01);
    tick_next = run && (cnt_reg == limit);
    cnt_next = (!run || cnt_reg == limit) ? '0 : cnt_reg + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  // ****************************************
  // Checks
  // ****************************************
  tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && div_sel == 3'h1 && $stable(div_sel)) |=> !tick ##1 (tick || !run))
    else $error("divide-by-two tick spacing wrong");

endmodule

// ### rtl/adc_conversion_sequencer.sv
// Converter control: APB registers, start handshake, sample/convert sequence
`timescale 1ns/1ps
module adc_conversion_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_high,
  output logic converter_power_on,
  output logic sample_hold_en,
  output logic [adc_seq_pkg::THR_W-1:0] dac_threshold,
  output logic [adc_seq_pkg::PIN_COUNT-1:0] analog_input_pins_connect,
  output logic [adc_seq_pkg::PIN_COUNT-1:0] pin_analog_enable,
  output logic protection_amp_output_connect,
  output logic ground_connect,
  output logic conversion_busy_flag,
  output logic converter_irq
);

  // ****************************************
  // State
  // ****************************************
  adc_seq_pkg::ctrl_t ctrl_reg, ctrl_next;
  adc_seq_pkg::seq_state_t state_reg, state_next;
  logic [3:0] tick_cnt_reg, tick_cnt_next;
  logic [3:0] bit_idx_reg, bit_idx_next;
  logic [adc_seq_pkg::RESULT_W-1:0] trial_reg, trial_next;
  logic [adc_seq_pkg::RESULT_W-1:0] result_reg, result_next;
  logic [adc_seq_pkg::THR_W-1:0] thr_reg, thr_next;
  logic flag_reg, flag_next;
  logic busy_reg, busy_next;
  logic irq_reg, irq_next;
  logic sample_reg, sample_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [adc_seq_pkg::PIN_COUNT-1:0] pin_conn_reg, pin_conn_next;
  logic amp_reg, amp_next;
  logic gnd_reg, gnd_next;
  logic comp_meta_reg, comp_sync_reg;
  logic tick;
  logic run;
  logic wr;
  logic done;
  logic start_fall;
  adc_seq_pkg::route_t route;

  // ****************************************
  // Comparator synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comparator_high;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ****************************************
  // Converter clock
  // ****************************************
  assign run = (state_reg == adc_seq_pkg::ST_SAMPLE) || (state_reg == adc_seq_pkg::ST_CONVERT);

  converter_clock_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .div_sel(ctrl_reg.div_sel),
    .tick(tick)
  );

  // ****************************************
  // APB slave and register file
  // ****************************************
  function automatic logic [7:0] result_byte(input logic [11:0] r, input logic fmt,
                                             input logic high);
    if (!fmt) begin
      return high ? r[11:4] : {r[3:0], 4'h0};
    end
    return high ? {4'h0, r[11:8]} : r[7:0];
  endfunction

  // Zero-wait slave; a running conversion never holds the bus
  assign wr = psel && penable && pready_reg && pwrite;

  always_comb begin
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel && !penable) begin
      prdata_next = '0;
      case (paddr)
        adc_seq_pkg::CTRL_ZERO_OFF: begin
          prdata_next[adc_seq_pkg::CHAN_LSB +: 4] = ctrl_reg.chan;
          prdata_next[adc_seq_pkg::FORMAT_BIT] = ctrl_reg.fmt;
          prdata_next[adc_seq_pkg::POWER_BIT] = ctrl_reg.power;
          prdata_next[adc_seq_pkg::BUSY_BIT] = busy_reg;
          prdata_next[adc_seq_pkg::START_BIT] = ctrl_reg.start;
        end
        adc_seq_pkg::CTRL_ONE_OFF: begin
          prdata_next[adc_seq_pkg::DIV_LSB +: 3] = ctrl_reg.div_sel;
          prdata_next[adc_seq_pkg::SOURCE_LSB +: 3] = ctrl_reg.source_sel;
        end
        adc_seq_pkg::PIN_ENABLE_OFF: begin
          prdata_next[3:0] = ctrl_reg.pin_en;
        end
        adc_seq_pkg::IRQ_CTRL_OFF: begin
          prdata_next[adc_seq_pkg::GIE_BIT] = ctrl_reg.gie;
          prdata_next[adc_seq_pkg::CIE_BIT] = ctrl_reg.cie;
          prdata_next[adc_seq_pkg::FLAG_BIT] = flag_reg;
        end
        adc_seq_pkg::RESULT_HIGH_OFF: begin
          prdata_next[7:0] = result_byte(result_reg, ctrl_reg.fmt, 1'b1);
        end
        adc_seq_pkg::RESULT_LOW_OFF: begin
          prdata_next[7:0] = result_byte(result_reg, ctrl_reg.fmt, 1'b0);
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr) begin
      case (paddr)
        adc_seq_pkg::CTRL_ZERO_OFF: begin
          ctrl_next.chan = pwdata[adc_seq_pkg::CHAN_LSB +: 4];
          ctrl_next.fmt = pwdata[adc_seq_pkg::FORMAT_BIT];
          ctrl_next.power = pwdata[adc_seq_pkg::POWER_BIT];
          ctrl_next.start = pwdata[adc_seq_pkg::START_BIT];
        end
        adc_seq_pkg::CTRL_ONE_OFF: begin
          ctrl_next.div_sel = pwdata[adc_seq_pkg::DIV_LSB +: 3];
          ctrl_next.source_sel = pwdata[adc_seq_pkg::SOURCE_LSB +: 3];
        end
        adc_seq_pkg::PIN_ENABLE_OFF: begin
          ctrl_next.pin_en = pwdata[3:0];
        end
        adc_seq_pkg::IRQ_CTRL_OFF: begin
          ctrl_next.gie = pwdata[adc_seq_pkg::GIE_BIT];
          ctrl_next.cie = pwdata[adc_seq_pkg::CIE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Conversion sequence
  // ****************************************
  assign start_fall = ctrl_reg.start && !ctrl_next.start;

  always_comb begin
    state_next = state_reg;
    tick_cnt_next = tick_cnt_reg;
    bit_idx_next = bit_idx_reg;
    trial_next = trial_reg;
    result_next = result_reg;
    done = 1'b0;
    case (state_reg)
      adc_seq_pkg::ST_IDLE, adc_seq_pkg::ST_SAMPLE, adc_seq_pkg::ST_CONVERT: begin
        if (state_reg == adc_seq_pkg::ST_SAMPLE && tick) begin
          tick_cnt_next = tick_cnt_reg + 4'h1;
          if (tick_cnt_reg == 4'(adc_seq_pkg::SAMPLE_TICKS - 1)) begin
            state_next = adc_seq_pkg::ST_CONVERT;
            bit_idx_next = 4'(adc_seq_pkg::RESULT_W - 1);
            trial_next = 12'h800;
          end
        end else if (state_reg == adc_seq_pkg::ST_CONVERT && tick) begin
          tick_cnt_next = tick_cnt_reg + 4'h1;
          // Keep the trial bit only when the input lies above its threshold
          if (!comp_sync_reg) begin
            trial_next[bit_idx_reg] = 1'b0;
          end
          if (bit_idx_reg == 4'h0) begin
            done = 1'b1;
            result_next = trial_next;
            state_next = adc_seq_pkg::ST_IDLE;
          end else begin
            bit_idx_next = bit_idx_reg - 4'h1;
            trial_next[bit_idx_reg - 4'h1] = 1'b1;
          end
        end
        // Start high resets the converter and aborts any conversion
        if (ctrl_next.start && !ctrl_reg.start) begin
          state_next = adc_seq_pkg::ST_ARMED;
          done = 1'b0;
          result_next = result_reg;
        end
      end
      adc_seq_pkg::ST_ARMED: begin
        tick_cnt_next = 4'h0;
        trial_next = '0;
        if (start_fall) begin
          state_next = adc_seq_pkg::ST_SAMPLE;
        end
      end
      default: begin
        state_next = adc_seq_pkg::ST_IDLE;
      end
    endcase
    if (!ctrl_reg.power) begin
      state_next = adc_seq_pkg::ST_IDLE;
      done = 1'b0;
      result_next = result_reg;
    end
  end

  always_comb begin
    busy_next = (state_next == adc_seq_pkg::ST_SAMPLE) ||
                (state_next == adc_seq_pkg::ST_CONVERT);
    sample_next = state_next == adc_seq_pkg::ST_SAMPLE;
    thr_next = adc_seq_pkg::threshold_of(trial_next);
    // A completion in the clearing cycle keeps the flag set
    flag_next = flag_reg;
    if (wr && paddr == adc_seq_pkg::IRQ_CTRL_OFF && !pwdata[adc_seq_pkg::FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (done) begin
      flag_next = 1'b1;
    end
    irq_next = flag_next && ctrl_next.gie && ctrl_next.cie;
    route = adc_seq_pkg::route_of(ctrl_next.source_sel, ctrl_next.chan);
    pin_conn_next = '0;
    if (route == adc_seq_pkg::ROUTE_PIN && ctrl_next.power) begin
      pin_conn_next[ctrl_next.chan[1:0]] = ctrl_next.pin_en[ctrl_next.chan[1:0]];
    end
    amp_next = ctrl_next.power && route == adc_seq_pkg::ROUTE_AMP;
    gnd_next = ctrl_next.power && route == adc_seq_pkg::ROUTE_GND;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= adc_seq_pkg::CTRL_RESET;
      state_reg <= adc_seq_pkg::ST_IDLE;
      tick_cnt_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      trial_reg <= '0;
      result_reg <= '0;
      thr_reg <= '0;
      flag_reg <= 1'b0;
      busy_reg <= 1'b0;
      irq_reg <= 1'b0;
      sample_reg <= 1'b0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      pin_conn_reg <= '0;
      amp_reg <= 1'b0;
      gnd_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      bit_idx_reg <= bit_idx_next;
      trial_reg <= trial_next;
      result_reg <= result_next;
      thr_reg <= thr_next;
      flag_reg <= flag_next;
      busy_reg <= busy_next;
      irq_reg <= irq_next;
      sample_reg <= sample_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      pin_conn_reg <= pin_conn_next;
      amp_reg <= amp_next;
      gnd_reg <= gnd_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign converter_power_on = ctrl_reg.power;
  assign sample_hold_en = sample_reg;
  assign dac_threshold = thr_reg;
  assign analog_input_pins_connect = pin_conn_reg;
  assign pin_analog_enable = ctrl_reg.pin_en;
  assign protection_amp_output_connect = amp_reg;
  assign ground_connect = gnd_reg;
  assign conversion_busy_flag = busy_reg;
  assign converter_irq = irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sample_phase_len_a: assert property (
    (state_reg == adc_seq_pkg::ST_SAMPLE && tick && tick_cnt_reg == 4'h3 && ctrl_reg.power
     && !(ctrl_next.start && !ctrl_reg.start)) |=> state_reg == adc_seq_pkg::ST_CONVERT)
    else $error("sample phase not four ticks");

  total_ticks_a: assert property (done |-> tick && tick_cnt_reg == 4'hf)
    else $error("conversion not sixteen ticks");

  bus_never_waits_a: assert property ((psel && !penable) |=> pready)
    else $error("bus stalled");

  power_off_idle_a: assert property (!ctrl_reg.power |=> !busy_reg && !sample_hold_en)
    else $error("converter active while unpowered");

  amp_route_a: assert property (
    protection_amp_output_connect |-> $past(ctrl_next.source_sel) == 3'h1 && !ground_connect
    && analog_input_pins_connect == 4'h0)
    else $error("amplifier route wrong");

  flag_set_a: assert property (done |=> flag_reg && !busy_reg)
    else $error("completion flag not set");

  irq_gate_a: assert property (converter_irq == (flag_reg && ctrl_reg.gie && ctrl_reg.cie))
    else $error("interrupt gating wrong");

  start_launch_a: assert property (
    (state_reg == adc_seq_pkg::ST_ARMED && start_fall && ctrl_reg.power) |=> busy_reg
    ##1 (busy_reg || !ctrl_reg.power || state_reg == adc_seq_pkg::ST_ARMED))
    else $error("start pulse did not launch");

  busy_held_a: assert property (run |-> busy_reg)
    else $error("busy low during conversion");

  result_commit_a: assert property (done |=> result_reg == $past(trial_next))
    else $error("result not committed");

  half_step_a: assert property ((dac_threshold != '0) |-> dac_threshold[0])
    else $error("threshold not half step low");

  conv_done_c: cover property (done);
  amp_conv_c: cover property (done && amp_reg);
  right_align_c: cover property (done && ctrl_reg.fmt && ctrl_reg.div_sel == 3'h2);
  abort_c: cover property (run ##1 state_reg == adc_seq_pkg::ST_ARMED);

endmodule

// ### sim/analog_front_model.sv
// Analog front end behind the sequencer: pins, amplifier output and ground
`timescale 1ns/1ps
module analog_front_model (
  input wire logic pclk,
  input wire logic [adc_seq_pkg::THR_W-1:0] dac_threshold,
  input wire logic [3:0] analog_input_pins_connect,
  input wire logic protection_amp_output_connect,
  input wire logic ground_connect,
  input wire logic converter_power_on,
  input wire logic [3:0][12:0] pin_level,
  input wire logic [12:0] amp_level,
  output logic comparator_high
);
  logic [12:0] level;
  logic live;
  logic wobble = 1'b0;
  // Nothing connected means no defined answer, so never a steady level
  always @(posedge pclk) wobble <= ~wobble;
  always_comb begin
    live = converter_power_on;
    level = 13'h0000;
    if (ground_connect) begin
      level = 13'h0000;
    end else if (protection_amp_output_connect) begin
      level = amp_level;
    end else if ($onehot(analog_input_pins_connect)) begin
      for (int i = 0; i < 4; i++) begin
        if (analog_input_pins_connect[i]) level = pin_level[i];
      end
    end else begin
      live = 1'b0;
    end
    // Levels in half steps, so each transition lands half a step early
    comparator_high = live ? (level > dac_threshold) : wobble;
  end
endmodule

// ### sim/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer with an analog front model
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
  localparam logic [7:0] a_cz = adc_seq_pkg::CTRL_ZERO_OFF;
  localparam logic [7:0] a_c1 = adc_seq_pkg::CTRL_ONE_OFF;
  localparam logic [7:0] a_pin = adc_seq_pkg::PIN_ENABLE_OFF;
  localparam logic [7:0] a_irq = adc_seq_pkg::IRQ_CTRL_OFF;
  localparam logic [7:0] a_hi = adc_seq_pkg::RESULT_HIGH_OFF;
  localparam logic [7:0] a_lo = adc_seq_pkg::RESULT_LOW_OFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmp_high, power_on, sh_en, busy, irq, amp_conn, gnd_conn;
  logic [adc_seq_pkg::THR_W-1:0] thr;
  logic [3:0] pin_conn, pin_en;
  logic [3:0][12:0] pin_level = '0;
  logic [12:0] amp_level = 13'h0000;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [7:0] cz = 8'h20;
  int err_total = 0;
  int checks = 0;
  int bl = 0, bs = 0, last_len = 0, last_sh = 0, seed;
  int edge_v[6] = '{0, 1, 2, 3, 8190, 8191};
  logic ext;
  logic fmt_pick = 1'b0;

  always #5 pclk = ~pclk;

  adc_conversion_sequencer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_high(cmp_high), .converter_power_on(power_on),
    .sample_hold_en(sh_en), .dac_threshold(thr), .analog_input_pins_connect(pin_conn),
    .pin_analog_enable(pin_en), .protection_amp_output_connect(amp_conn),
    .ground_connect(gnd_conn), .conversion_busy_flag(busy), .converter_irq(irq));

  analog_front_model u_front (.pclk(pclk), .dac_threshold(thr),
    .analog_input_pins_connect(pin_conn), .protection_amp_output_connect(amp_conn),
    .ground_connect(gnd_conn), .converter_power_on(power_on), .pin_level(pin_level),
    .amp_level(amp_level), .comparator_high(cmp_high));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(33'h0, 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    notes.push_back({1'b0, e, 32'h0});
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    notes.push_back({1'b1, e, d});
    apb(1'b0, a, 32'h0);
  endtask

  // Monitor: bus answers against notes, busy and sampling spans measured
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check({pslverr, note[33] ? prdata : 32'h0}, {note[32], note[33] ? note[31:0] : 32'h0});
    end
    if (busy === 1'b1) begin
      bl++;
      bs += int'(sh_en);
    end else if (bl != 0) begin
      last_len = bl;
      last_sh = bs;
      bl = 0;
      bs = 0;
    end
  end

  // Channel before source, so internal sources never meet a live pin
  task automatic go(input logic [2:0] div, input logic [2:0] src, input logic [3:0] ch);
    int n;
    cz = {3'h1, fmt_pick, ch};
    // Divider set while powered down, channel parked before the source moves
    wr(a_cz, {24'h0, cz & 8'hdf});
    wr(a_c1, {24'h0, src, 2'b00, div});
    wr(a_cz, {24'h0, cz});
    wr(a_cz, {24'h0, cz | 8'h80});
    wr(a_cz, {24'h0, cz});
    n = 0;
    while (busy !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    check(33'(busy), 33'h1);
  endtask

  task automatic convert(input logic [2:0] div, input logic [2:0] src, input logic [3:0] ch,
                         input logic mid);
    int n;
    go(div, src, ch);
    if (mid) rd(a_cz, {24'h0, cz | 8'h40});
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    check(33'(last_len >= (16 << div) - 1 && last_len <= (16 << div) + 2), 33'h1);
    check(33'(last_sh >= (4 << div) - 1 && last_sh <= (4 << div) + 2), 33'h1);
  endtask

  task automatic result_is(input logic [11:0] r);
    wr(a_hi, 32'hff);
    wr(a_cz, {24'h0, cz | 8'h10});
    rd(a_hi, {28'h0, r[11:8]});
    rd(a_lo, {24'h0, r[7:0]});
    wr(a_cz, {24'h0, cz & 8'hef});
    rd(a_hi, {24'h0, r[11:4]});
    rd(a_lo, {24'h0, r[3:0], 4'h0});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = $urandom(95);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0);
    rd(8'h18, 32'h0, 1'b1);
    wr(8'h18, 32'hff, 1'b1);
    wr(a_pin, 32'hf);
    rd(a_pin, 32'hf);
    check(33'(pin_en), 33'hf);
    for (int c = 0; c < 4; c++) begin
      pin_level[c] <= 13'($urandom);
      convert(3'd2, 3'd0, 4'(c), c == 0);
      result_is(pin_level[c][12:1]);
    end
    for (int i = 0; i < 6; i++) begin
      pin_level[1] <= 13'(edge_v[i]);
      fmt_pick = (i == 4);
      convert(3'd2, 3'd0, 4'd1, 1'b0);
      result_is(12'(edge_v[i] >> 1));
    end
    amp_level <= 13'($urandom);
    for (int s = 0; s < 8; s++) begin
      ext = (s == 0 || s > 4);
      convert(3'd3, 3'(s), ext ? 4'd2 : 4'd6, 1'b0);
      check(33'({amp_conn, gnd_conn, pin_conn}), 33'({s == 1, s > 1 && s < 5, ext ? 4'h4 : 4'h0}));
      result_is(s == 1 ? amp_level[12:1] : ext ? pin_level[2][12:1] : 12'h000);
    end
    wr(a_pin, 32'hb);
    @(posedge pclk);
    check(33'(pin_conn), 33'h0);
    wr(a_pin, 32'hf);
    for (int d = 0; d < 8; d++) convert(3'(d), 3'd2, 4'd6, 1'b0);
    wr(a_irq, 32'h3);
    convert(3'd2, 3'd2, 4'd6, 1'b0);
    check(33'(irq), 33'h1);
    rd(a_irq, 32'h7);
    wr(a_irq, 32'h3);
    rd(a_irq, 32'h3);
    check(33'(irq), 33'h0);
    wr(a_irq, 32'h0);
    convert(3'd2, 3'd2, 4'd6, 1'b0);
    rd(a_irq, 32'h4);
    check(33'(irq), 33'h0);
    wr(a_irq, 32'h0);
    go(3'd7, 3'd2, 4'd6);
    wr(a_cz, {24'h0, cz & 8'hdf});
    repeat (2) @(posedge pclk);
    check(33'({busy, power_on, gnd_conn}), 33'h0);
    rd(a_irq, 32'h0);
    go(3'd7, 3'd2, 4'd6);
    wr(a_cz, {24'h0, cz | 8'h80});
    repeat (2) @(posedge pclk);
    check(33'(busy), 33'h0);
    convert(3'd0, 3'd2, 4'd6, 1'b1);
    tally_and_finish();
  end

  initial begin
    #300000;
    err_total++;
    tally_and_finish();
  end
endmodule
